// >>> design/cag_pkg.sv
package cag_pkg;

    // ==========================================================
    // Widths
    // ==========================================================
    localparam int PA_W = 20;
    localparam int OFF_W = 12;
    localparam int PAGE_W = 8;
    localparam int DA_W = 16;
    localparam int BYTE_W = 8;
    localparam int WORD_W = 16;
    localparam int GPR_SEL_W = 2;
    localparam int GPR_BANK_W = 2;
    localparam int GPR_COUNT = 16;
    localparam int IDX_BANKS = 2;

    // ==========================================================
    // Program address map
    // ==========================================================
    localparam logic [PA_W-1:0] RESET_VECTOR = 20'h00000;
    localparam logic [PA_W-1:0] VECTOR_LAST = 20'h00004;
    localparam logic [PA_W-1:0] OPT_ADDR_FIRST = 20'h0001E;
    localparam logic [PA_W-1:0] OPT_ADDR_SECOND = 20'h0001F;
    localparam logic [PA_W-1:0] PROG_START = 20'h00020;
    localparam logic [PA_W-1:0] PROG_LAST = 20'h01FFF;
    localparam logic [OFF_W-1:0] OFF_STEP = 12'h001;

    // ==========================================================
    // Data address map
    // ==========================================================
    localparam logic [DA_W-1:0] DA_PERIPH_LAST = 16'h007F;
    localparam logic [DA_W-1:0] DA_STORE_FIRST = 16'h0080;
    localparam logic [DA_W-1:0] DA_STORE_LAST = 16'h047F;
    localparam logic [PAGE_W-1:0] DIRECT_PAGE_ZERO = 8'h00;
    localparam logic [PAGE_W-1:0] BYTE_ZERO = 8'h00;

    // ==========================================================
    // Option word and control flag layout
    // ==========================================================
    localparam logic [WORD_W-1:0] OPT_BLANK = 16'hFFFF;
    localparam int OPT_BT_LSB = 12;
    localparam int OPT_BT_W = 3;
    localparam int OPT_WDT_BIT = 11;
    localparam int SCF_EID = 0;
    localparam int SCF_IDB = 2;
    localparam int SCF_GRB_LSB = 3;
    localparam logic [BYTE_W-1:0] SCF_RESET = 8'h00;

    // ==========================================================
    // Operation codes
    // ==========================================================
    typedef enum logic [1:0] {
        CAG_PC_HOLD, CAG_PC_SEQ, CAG_PC_SHORT, CAG_PC_LONG
    } cag_pc_op_t;

    typedef enum logic [1:0] {
        CAG_DM_NONE, CAG_DM_INDEX, CAG_DM_INDEX_MOD, CAG_DM_DIRECT
    } cag_dm_op_t;

    typedef enum logic [2:0] {
        CAG_SPR_NONE, CAG_SPR_FROM_GPR, CAG_SPR_TO_GPR, CAG_SPR_POP,
        CAG_SPR_PUSH
    } cag_spr_op_t;

    typedef enum logic [2:0] {
        CAG_SR_IDX_OFF0, CAG_SR_IDX_OFF1, CAG_SR_IDX_PAGE, CAG_SR_SCF,
        CAG_SR_ALU_FLAGS, CAG_SR_LINK_EXT, CAG_SR_LINK_HIGH, CAG_SR_LINK_LOW
    } cag_spr_sel_t;

endpackage

// >>> design/cag_core.sv
// Summary of operation
// - 20-bit program address, page 19:12, offset 11:0
// - Sequential step wraps offset, page kept
// - Only long branches load full 20-bit target
// - Short branch adds displacement to offset only
// - 16-bit data address, page high byte
// - Index address is page byte plus offset byte
// - Direct field gives offset within selected page
// - Direct page zero unless direct-page flag set
// - Pointer modify carries across full 16 bits
// - Vector area 00000H-00004H, program from 00020H; pc_in_vector_area flags every address below 00020H
// - Fetch option words 0001EH, 0001FH after power-on
// - Timer clock bits 14:12, watchdog bit 11
// - Blank option bits read as ones
// - 8K words implemented, program up to 1FFFH
// - Peripheral 0000H-007FH, storage 0080H-047FH
// - Four banks of four registers, bank flags 4:3
// - Two index banks chosen by flag bit 2
// - ALU operands always from current bank
// - No ALU on special registers, moves allowed
`timescale 1ns/10ps

module cag_core
    import cag_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire cag_pc_op_t pc_op,
    input wire logic [OFF_W-1:0] pc_disp,
    input wire logic [PA_W-1:0] pc_target,
    input wire logic [WORD_W-1:0] prog_data,
    input wire cag_dm_op_t dm_op,
    input wire logic dm_use_second,
    input wire logic [BYTE_W-1:0] dm_direct,
    input wire logic dm_mod_sub,
    input wire logic [BYTE_W-1:0] dm_mod_amt,
    input wire cag_spr_op_t spr_op,
    input wire cag_spr_sel_t spr_sel,
    input wire logic [GPR_SEL_W-1:0] gpr_sel,
    input wire logic [BYTE_W-1:0] stack_rdata,
    input wire logic [GPR_SEL_W-1:0] alu_src_a,
    input wire logic [GPR_SEL_W-1:0] alu_src_b,
    input wire logic alu_wr,
    input wire logic [GPR_SEL_W-1:0] alu_dst,
    input wire logic [BYTE_W-1:0] alu_result,
    input wire logic [BYTE_W-1:0] alu_flags_in,
    output logic [PA_W-1:0] program_address_bus,
    output logic opt_loaded,
    output logic [WORD_W-1:0] power_on_option_word,
    output logic [OPT_BT_W-1:0] bt_clk_sel,
    output logic wdt_enable,
    output logic pc_in_vector_area,
    output logic pc_out_of_range,
    output logic [DA_W-1:0] data_address_bus,
    output logic data_access,
    output logic data_is_periph,
    output logic data_is_storage,
    output logic [BYTE_W-1:0] alu_opnd_a,
    output logic [BYTE_W-1:0] alu_opnd_b,
    output logic [BYTE_W-1:0] stack_wdata,
    output logic [BYTE_W-1:0] system_control_flags,
    output logic [BYTE_W-1:0] alu_status_flags
);

    // ==========================================================
    // Functions
    // ==========================================================
    function automatic logic [PA_W-1:0] page_step(
        input logic [PA_W-1:0] pc,
        input logic [OFF_W-1:0] delta
    );
        // Offset arithmetic stays 12 bits wide so a carry never
        // reaches the page index
        page_step = {pc[PA_W-1:OFF_W], pc[OFF_W-1:0] + delta};
    endfunction

    function automatic logic [DA_W-1:0] ptr_step(
        input logic [DA_W-1:0] ptr,
        input logic [BYTE_W-1:0] amt,
        input logic sub
    );
        if (sub) begin
            ptr_step = ptr - {BYTE_ZERO, amt};
        end else begin
            ptr_step = ptr + {BYTE_ZERO, amt};
        end
    endfunction

    function automatic logic [WORD_W-1:0] rom_word(
        input logic [PA_W-1:0] addr,
        input logic [WORD_W-1:0] data
    );
        // Past the implemented array the word reads as blank
        rom_word = (addr > PROG_LAST) ? OPT_BLANK : data;
    endfunction

    // ==========================================================
    // State
    // ==========================================================
    typedef enum logic [1:0] {
        CAG_ST_OPT_FIRST, CAG_ST_OPT_SECOND, CAG_ST_RUN
    } cag_state_t;

    cag_state_t state_r;
    logic [PA_W-1:0] pc_r;
    logic [WORD_W-1:0] opt_first_r;
    logic [WORD_W-1:0] opt_second_r;
    logic [BYTE_W-1:0] scf_r;
    logic [BYTE_W-1:0] asf_r;
    logic [BYTE_W-1:0] link_ext_r;
    logic [BYTE_W-1:0] link_high_r;
    logic [BYTE_W-1:0] link_low_r;
    logic [BYTE_W-1:0] gpr_r [GPR_COUNT];
    logic [PAGE_W-1:0] idx_page_r [IDX_BANKS];
    logic [BYTE_W-1:0] idx_off0_r [IDX_BANKS];
    logic [BYTE_W-1:0] idx_off1_r [IDX_BANKS];
    logic [DA_W-1:0] da_r;
    logic da_valid_r;
    logic da_periph_r;
    logic da_storage_r;
    logic [BYTE_W-1:0] opnd_a_r;
    logic [BYTE_W-1:0] opnd_b_r;
    logic [BYTE_W-1:0] stack_wdata_r;

    logic run;
    logic [GPR_BANK_W-1:0] grb;
    logic idb;
    logic [PAGE_W-1:0] cur_page;
    logic [BYTE_W-1:0] cur_off;
    logic [DA_W-1:0] idx_ptr;
    logic [DA_W-1:0] idx_ptr_nxt;
    logic [DA_W-1:0] da_nxt;
    logic [WORD_W-1:0] fetched;
    logic [BYTE_W-1:0] spr_val;
    logic [BYTE_W-1:0] spr_wdata;
    logic spr_wr;

    // ==========================================================
    // Bank selection and operand decode
    // ==========================================================
    assign run = (state_r == CAG_ST_RUN);
    assign grb = scf_r[SCF_GRB_LSB +: GPR_BANK_W];
    assign idb = scf_r[SCF_IDB];
    assign cur_page = idx_page_r[idb];
    assign cur_off = dm_use_second ? idx_off1_r[idb] : idx_off0_r[idb];
    assign idx_ptr = {cur_page, cur_off};
    assign idx_ptr_nxt = ptr_step(idx_ptr, dm_mod_amt, dm_mod_sub);
    assign fetched = rom_word(pc_r, prog_data);
    assign spr_wr = (spr_op == CAG_SPR_FROM_GPR) || (spr_op == CAG_SPR_POP);

    always_comb begin
        if (dm_op == CAG_DM_DIRECT) begin
            da_nxt = {scf_r[SCF_EID] ? cur_page : DIRECT_PAGE_ZERO,
                      dm_direct};
        end else begin
            da_nxt = idx_ptr;
        end
    end

    // Besides ALU flag updates and index post-modify, only moves and stack traffic touch special registers
    always_comb begin
        unique case (spr_sel)
            CAG_SR_IDX_OFF0: spr_val = idx_off0_r[idb];
            CAG_SR_IDX_OFF1: spr_val = idx_off1_r[idb];
            CAG_SR_IDX_PAGE: spr_val = idx_page_r[idb];
            CAG_SR_SCF: spr_val = scf_r;
            CAG_SR_ALU_FLAGS: spr_val = asf_r;
            CAG_SR_LINK_EXT: spr_val = link_ext_r;
            CAG_SR_LINK_HIGH: spr_val = link_high_r;
            CAG_SR_LINK_LOW: spr_val = link_low_r;
        endcase
    end

    assign spr_wdata = (spr_op == CAG_SPR_POP) ? stack_rdata
                                               : gpr_r[{grb, gpr_sel}];

    // ==========================================================
    // Power-on option fetch and program counter
    // ==========================================================
    // Program words are read combinationally from the address bus,
    // so each option word is taken in the cycle it is addressed
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_r <= CAG_ST_OPT_FIRST;
            pc_r <= OPT_ADDR_FIRST;
        end else if (ce) begin
            unique case (state_r)
                CAG_ST_OPT_FIRST: begin
                    state_r <= CAG_ST_OPT_SECOND;
                    pc_r <= OPT_ADDR_SECOND;
                end
                CAG_ST_OPT_SECOND: begin
                    state_r <= CAG_ST_RUN;
                    pc_r <= RESET_VECTOR;
                end
                CAG_ST_RUN: begin
                    unique case (pc_op)
                        CAG_PC_HOLD: pc_r <= pc_r;
                        CAG_PC_SEQ: pc_r <= page_step(pc_r, OFF_STEP);
                        CAG_PC_SHORT: pc_r <= page_step(pc_r, pc_disp);
                        CAG_PC_LONG: pc_r <= pc_target;
                    endcase
                end
            endcase
        end
    end

    // Blank array reads as all ones, so defaults hold until loaded
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            opt_first_r <= OPT_BLANK;
            opt_second_r <= OPT_BLANK;
        end else if (ce) begin
            if (state_r == CAG_ST_OPT_FIRST) begin
                opt_first_r <= fetched;
            end
            if (state_r == CAG_ST_OPT_SECOND) begin
                opt_second_r <= fetched;
            end
        end
    end

    // ==========================================================
    // Data address generation
    // ==========================================================
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            da_r <= '0;
            da_valid_r <= 1'b0;
            da_periph_r <= 1'b1;
            da_storage_r <= 1'b0;
        end else if (ce) begin
            da_valid_r <= run && (dm_op != CAG_DM_NONE);
            if (run && (dm_op != CAG_DM_NONE)) begin
                da_r <= da_nxt;
                // Region flags are registered with the address so the
                // outputs come from flops
                da_periph_r <= (da_nxt <= DA_PERIPH_LAST);
                da_storage_r <= (da_nxt >= DA_STORE_FIRST)
                             && (da_nxt <= DA_STORE_LAST);
            end
        end
    end

    // Index bytes carry no reset; software loads them before use
    always_ff @(posedge clk_sys) begin
        if (ce && run) begin
            if (dm_op == CAG_DM_INDEX_MOD) begin
                // Post-modify: the access uses the old pointer
                idx_page_r[idb] <= idx_ptr_nxt[DA_W-1:BYTE_W];
                if (dm_use_second) begin
                    idx_off1_r[idb] <= idx_ptr_nxt[BYTE_W-1:0];
                end else begin
                    idx_off0_r[idb] <= idx_ptr_nxt[BYTE_W-1:0];
                end
            end else if (spr_wr) begin
                if (spr_sel == CAG_SR_IDX_OFF0) begin
                    idx_off0_r[idb] <= spr_wdata;
                end
                if (spr_sel == CAG_SR_IDX_OFF1) begin
                    idx_off1_r[idb] <= spr_wdata;
                end
                if (spr_sel == CAG_SR_IDX_PAGE) begin
                    idx_page_r[idb] <= spr_wdata;
                end
            end
        end
    end

    // ==========================================================
    // Special registers
    // ==========================================================
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            scf_r <= SCF_RESET;
        end else if (ce && run && spr_wr && spr_sel == CAG_SR_SCF) begin
            scf_r <= spr_wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (ce && run) begin
            if (spr_wr && spr_sel == CAG_SR_ALU_FLAGS) begin
                asf_r <= spr_wdata;
            end else if (alu_wr) begin
                asf_r <= alu_flags_in;
            end
            if (spr_wr && spr_sel == CAG_SR_LINK_EXT) begin
                link_ext_r <= spr_wdata;
            end
            if (spr_wr && spr_sel == CAG_SR_LINK_HIGH) begin
                link_high_r <= spr_wdata;
            end
            if (spr_wr && spr_sel == CAG_SR_LINK_LOW) begin
                link_low_r <= spr_wdata;
            end
        end
    end

    // ==========================================================
    // General registers
    // ==========================================================
    // A bank index is never taken from the instruction, so an
    // operand pair cannot straddle two banks
    always_ff @(posedge clk_sys) begin
        if (ce && run) begin
            if (alu_wr) begin
                gpr_r[{grb, alu_dst}] <= alu_result;
            end else if (spr_op == CAG_SPR_TO_GPR) begin
                gpr_r[{grb, gpr_sel}] <= spr_val;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            opnd_a_r <= '0;
            opnd_b_r <= '0;
            stack_wdata_r <= '0;
        end else if (ce) begin
            opnd_a_r <= gpr_r[{grb, alu_src_a}];
            opnd_b_r <= gpr_r[{grb, alu_src_b}];
            if (run && spr_op == CAG_SPR_PUSH) begin
                stack_wdata_r <= spr_val;
            end
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign program_address_bus = pc_r;
    assign opt_loaded = run;
    assign power_on_option_word = opt_first_r;
    assign bt_clk_sel = opt_second_r[OPT_BT_LSB +: OPT_BT_W];
    assign wdt_enable = opt_second_r[OPT_WDT_BIT];
    assign pc_in_vector_area = (pc_r < PROG_START);
    assign pc_out_of_range = (pc_r > PROG_LAST);
    assign data_address_bus = da_r;
    assign data_access = da_valid_r;
    assign data_is_periph = da_periph_r;
    assign data_is_storage = da_storage_r;
    assign alu_opnd_a = opnd_a_r;
    assign alu_opnd_b = opnd_b_r;
    assign stack_wdata = stack_wdata_r;
    assign system_control_flags = scf_r;
    assign alu_status_flags = asf_r;

    // ==========================================================
    // Assertions
    // ==========================================================
    seq_wrap_a:
    assert property (@(posedge clk_sys) disable iff (rst)
        ce && run && pc_op == CAG_PC_SEQ |=>
        pc_r[PA_W-1:OFF_W] == $past(pc_r[PA_W-1:OFF_W])
        && pc_r[OFF_W-1:0] == $past(pc_r[OFF_W-1:0]) + OFF_STEP)
        else $error("sequential step left the page or skipped");

    short_page_a:
    assert property (@(posedge clk_sys) disable iff (rst)
        ce && run && pc_op == CAG_PC_SHORT |=>
        $stable(pc_r[PA_W-1:OFF_W])
        && pc_r[OFF_W-1:0] == $past(pc_r[OFF_W-1:0]) + $past(pc_disp))
        else $error("short branch changed page or offset wrong");

    long_load_a:
    assert property (@(posedge clk_sys) disable iff (rst)
        ce && run && pc_op != CAG_PC_LONG
        && !(pc_op == CAG_PC_HOLD) |=>
        pc_r[PA_W-1:OFF_W] == $past(pc_r[PA_W-1:OFF_W]))
        else $error("page changed without a long branch");

    opt_fetch_a:
    assert property (@(posedge clk_sys) disable iff (rst)
        ce && state_r == CAG_ST_OPT_FIRST |->
        pc_r == OPT_ADDR_FIRST ##1 (!ce || pc_r == OPT_ADDR_SECOND))
        else $error("option words not addressed in order");

    opt_apply_a:
    assert property (@(posedge clk_sys) disable iff (rst)
        ce && state_r == CAG_ST_OPT_SECOND |=>
        opt_loaded && pc_r == RESET_VECTOR
        && wdt_enable == $past(fetched[OPT_WDT_BIT])
        && bt_clk_sel == $past(fetched[OPT_BT_LSB +: OPT_BT_W]))
        else $error("option word not applied");

    direct_page_a:
    assert property (@(posedge clk_sys) disable iff (rst)
        ce && run && dm_op == CAG_DM_DIRECT && !scf_r[SCF_EID] |=>
        data_access && data_address_bus == {DIRECT_PAGE_ZERO,
                                            $past(dm_direct)})
        else $error("direct access not in page zero");

    ptr_carry_a:
    assert property (@(posedge clk_sys) disable iff (rst)
        ce && run && dm_op == CAG_DM_INDEX_MOD && !dm_mod_sub
        && !dm_use_second ##1 ce |->
        {idx_page_r[idb], idx_off0_r[idb]}
        == $past(idx_ptr) + {BYTE_ZERO, $past(dm_mod_amt)})
        else $error("pointer update lost the carry");

    scf_reset_a:
    assert property (@(posedge clk_sys)
        rst |-> scf_r == SCF_RESET)
        else $error("control flags not cleared by reset");

    region_a:
    assert property (@(posedge clk_sys) disable iff (rst)
        !(data_is_periph && data_is_storage))
        else $error("data address decoded into two regions");

endmodule

// >>> dv/cag_mem_model.sv
`timescale 1ns/10ps

module cag_mem_model
    import cag_pkg::*;
#(
    parameter logic [WORD_W-1:0] OPT_FIRST_WORD = 16'h0000,
    parameter logic [WORD_W-1:0] OPT_SECOND_WORD = 16'hBFFF
)
(
    input wire logic [PA_W-1:0] program_address_bus,
    output logic [WORD_W-1:0] prog_data
);
    // ==========================================================
    // Combinational program store
    // ==========================================================
    // Ordinary words depend on the address so a stale fetch shows up
    always_comb begin
        if (program_address_bus == OPT_ADDR_FIRST) begin
            prog_data = OPT_FIRST_WORD;
        end else if (program_address_bus == OPT_ADDR_SECOND) begin
            prog_data = OPT_SECOND_WORD;
        end else if (program_address_bus > PROG_LAST) begin
            prog_data = OPT_BLANK;
        end else begin
            prog_data = {program_address_bus[7:0], ~program_address_bus[7:0]};
        end
    end
endmodule

// >>> dv/testbench.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin errors++; \
    $display("unexpected %s: expected %h, seen %h", n, e, g); end end

module testbench
    import cag_pkg::*;
();
    // ==========================================================
    // Signals
    // ==========================================================
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    cag_pc_op_t pc_op = CAG_PC_HOLD;
    logic [OFF_W-1:0] pc_disp = 12'h000;
    logic [PA_W-1:0] pc_target = 20'h00000;
    logic [WORD_W-1:0] prog_data;
    cag_dm_op_t dm_op = CAG_DM_NONE;
    logic dm_use_second = 1'b0, dm_mod_sub = 1'b0, alu_wr = 1'b0;
    logic [BYTE_W-1:0] dm_direct = 8'h00, dm_mod_amt = 8'h00;
    cag_spr_op_t spr_op = CAG_SPR_NONE;
    cag_spr_sel_t spr_sel = CAG_SR_SCF;
    logic [GPR_SEL_W-1:0] gpr_sel = 2'h0, alu_src_a = 2'h0;
    logic [GPR_SEL_W-1:0] alu_src_b = 2'h0, alu_dst = 2'h0;
    logic [BYTE_W-1:0] stack_rdata = 8'h00, alu_result = 8'h00;
    logic [BYTE_W-1:0] alu_flags_in = 8'h00;
    logic [PA_W-1:0] program_address_bus;
    logic [WORD_W-1:0] power_on_option_word;
    logic [OPT_BT_W-1:0] bt_clk_sel;
    logic opt_loaded, wdt_enable, pc_in_vector_area, pc_out_of_range;
    logic [DA_W-1:0] data_address_bus;
    logic data_access, data_is_periph, data_is_storage;
    logic [BYTE_W-1:0] alu_opnd_a, alu_opnd_b, stack_wdata;
    logic [BYTE_W-1:0] system_control_flags, alu_status_flags;
    int errors = 0;
    int compares = 0;

    always #5 clk_sys = ~clk_sys;

    cag_core i_dut (.clk_sys, .rst, .ce, .pc_op, .pc_disp, .pc_target,
        .prog_data, .dm_op, .dm_use_second, .dm_direct, .dm_mod_sub,
        .dm_mod_amt, .spr_op, .spr_sel, .gpr_sel, .stack_rdata, .alu_src_a,
        .alu_src_b, .alu_wr, .alu_dst, .alu_result, .alu_flags_in,
        .program_address_bus, .opt_loaded, .power_on_option_word,
        .bt_clk_sel, .wdt_enable, .pc_in_vector_area, .pc_out_of_range,
        .data_address_bus, .data_access, .data_is_periph, .data_is_storage,
        .alu_opnd_a, .alu_opnd_b, .stack_wdata, .system_control_flags,
        .alu_status_flags);

    cag_mem_model i_mem (.program_address_bus, .prog_data);

    // ==========================================================
    // Access tasks, all entered and left at a falling edge
    // ==========================================================
    task automatic tick();
        @(posedge clk_sys);
        @(negedge clk_sys);
    endtask

    task automatic pc_step(cag_pc_op_t op, logic [11:0] d, logic [19:0] t);
        pc_op = op;
        pc_disp = d;
        pc_target = t;
        tick();
        pc_op = CAG_PC_HOLD;
    endtask

    task automatic wr_gpr(logic [1:0] r, logic [7:0] v);
        alu_wr = 1'b1;
        alu_dst = r;
        alu_result = v;
        alu_flags_in = ~v;
        tick();
        alu_wr = 1'b0;
    endtask

    task automatic special_register(cag_spr_op_t op, cag_spr_sel_t s, logic [1:0] r);
        spr_op = op;
        spr_sel = s;
        gpr_sel = r;
        tick();
        spr_op = CAG_SPR_NONE;
    endtask

    // Goes through R0 of the current bank, so R0 is lost
    task automatic to_spr(cag_spr_sel_t s, logic [7:0] v);
        wr_gpr(2'h0, v);
        special_register(CAG_SPR_FROM_GPR, s, 2'h0);
    endtask

    task automatic dm(cag_dm_op_t op, logic sec, logic [7:0] a, logic sub,
        logic [15:0] exp);
        dm_op = op;
        dm_use_second = sec;
        dm_direct = a;
        dm_mod_amt = a;
        dm_mod_sub = sub;
        tick();
        dm_op = CAG_DM_NONE;
        `CHK("data_address_bus", exp, data_address_bus)
        `CHK("data_access", 1'b1, data_access)
    endtask

    task automatic end_sim();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Tests
    // ==========================================================
    initial begin
        repeat (10) @(negedge clk_sys);
        `CHK("pa", 20'h0001E, program_address_bus)
        `CHK("scf", 8'h00, system_control_flags)
        `CHK("bt", 3'h7, bt_clk_sel)
        `CHK("opt", 16'hFFFF, power_on_option_word)
        rst = 1'b0;
        tick();
        `CHK("pa", 20'h0001F, program_address_bus)
        `CHK("loaded", 1'b0, opt_loaded)
        tick();
        `CHK("pa", 20'h00000, program_address_bus)
        `CHK("loaded", 1'b1, opt_loaded)
        `CHK("opt", 16'h0000, power_on_option_word)
        `CHK("bt", 3'h3, bt_clk_sel)
        `CHK("wdt", 1'b1, wdt_enable)
        `CHK("vec", 1'b1, pc_in_vector_area)
        pc_step(CAG_PC_LONG, 12'h000, 20'h5EFFF);
        pc_step(CAG_PC_SEQ, 12'h000, 20'h00000);
        `CHK("pa", 20'h5E000, program_address_bus)
        pc_step(CAG_PC_LONG, 12'h000, 20'h6FFFE);
        pc_step(CAG_PC_SHORT, 12'h005, 20'h00000);
        `CHK("pa", 20'h6F003, program_address_bus)
        pc_step(CAG_PC_HOLD, 12'h000, 20'h00000);
        `CHK("pa", 20'h6F003, program_address_bus)
        pc_step(CAG_PC_LONG, 12'h000, 20'hA507F);
        `CHK("pa", 20'hA507F, program_address_bus)
        ce = 1'b0;
        pc_step(CAG_PC_LONG, 12'h000, 20'h12345);
        ce = 1'b1;
        `CHK("pa", 20'hA507F, program_address_bus)
        pc_step(CAG_PC_LONG, 12'h000, 20'h01FFF);
        `CHK("range", 1'b0, pc_out_of_range)
        pc_step(CAG_PC_SEQ, 12'h000, 20'h00000);
        `CHK("pa", 20'h01000, program_address_bus)
        pc_step(CAG_PC_LONG, 12'h000, 20'h02000);
        `CHK("range", 1'b1, pc_out_of_range)
        pc_step(CAG_PC_LONG, 12'h000, 20'h0001F);
        `CHK("vec", 1'b1, pc_in_vector_area)
        pc_step(CAG_PC_SEQ, 12'h000, 20'h00000);
        `CHK("vec", 1'b0, pc_in_vector_area)
        to_spr(CAG_SR_IDX_PAGE, 8'h0F);
        to_spr(CAG_SR_IDX_OFF0, 8'hFC);
        dm(CAG_DM_INDEX_MOD, 1'b0, 8'h05, 1'b0, 16'h0FFC);
        dm(CAG_DM_INDEX, 1'b0, 8'h00, 1'b0, 16'h1001);
        dm(CAG_DM_INDEX_MOD, 1'b0, 8'h02, 1'b1, 16'h1001);
        dm(CAG_DM_INDEX, 1'b0, 8'h00, 1'b0, 16'h0FFF);
        tick();
        `CHK("data_access", 1'b0, data_access)
        dm(CAG_DM_DIRECT, 1'b0, 8'h7F, 1'b0, 16'h007F);
        `CHK("periph", 1'b1, data_is_periph)
        to_spr(CAG_SR_SCF, 8'h01);
        dm(CAG_DM_DIRECT, 1'b0, 8'h80, 1'b0, 16'h0F80);
        to_spr(CAG_SR_IDX_PAGE, 8'h00);
        to_spr(CAG_SR_IDX_OFF1, 8'h80);
        dm(CAG_DM_INDEX, 1'b1, 8'h00, 1'b0, 16'h0080);
        `CHK("storage", 1'b1, data_is_storage)
        to_spr(CAG_SR_IDX_PAGE, 8'h04);
        dm(CAG_DM_INDEX, 1'b1, 8'h00, 1'b0, 16'h0480);
        `CHK("storage", 1'b0, data_is_storage)
        `CHK("periph", 1'b0, data_is_periph)
        to_spr(CAG_SR_SCF, 8'h04);
        to_spr(CAG_SR_IDX_PAGE, 8'h20);
        to_spr(CAG_SR_IDX_OFF0, 8'h33);
        dm(CAG_DM_INDEX, 1'b0, 8'h00, 1'b0, 16'h2033);
        to_spr(CAG_SR_SCF, 8'h00);
        dm(CAG_DM_INDEX, 1'b0, 8'h00, 1'b0, 16'h04FF);
        wr_gpr(2'h1, 8'h11);
        to_spr(CAG_SR_SCF, 8'h08);
        `CHK("scf", 8'h08, system_control_flags)
        wr_gpr(2'h1, 8'h22);
        alu_src_a = 2'h1;
        alu_src_b = 2'h1;
        tick();
        `CHK("opnd_a", 8'h22, alu_opnd_a)
        `CHK("opnd_b", 8'h22, alu_opnd_b)
        to_spr(CAG_SR_SCF, 8'h00);
        tick();
        `CHK("opnd_a", 8'h11, alu_opnd_a)
        special_register(CAG_SPR_PUSH, CAG_SR_IDX_PAGE, 2'h0);
        `CHK("stack_wdata", 8'h04, stack_wdata)
        stack_rdata = 8'h5A;
        special_register(CAG_SPR_POP, CAG_SR_ALU_FLAGS, 2'h0);
        `CHK("alu_flags", 8'h5A, alu_status_flags)
        special_register(CAG_SPR_TO_GPR, CAG_SR_ALU_FLAGS, 2'h2);
        alu_src_a = 2'h2;
        tick();
        `CHK("opnd_a", 8'h5A, alu_opnd_a)
        end_sim();
    end

    // Tests need well under 200 cycles
    initial begin
        #20000;
        errors++;
        end_sim();
    end
endmodule
